/* lbc_unit.sv */
// program-flow unit: label markers, jump, call/return stack and decrement loop
// assumes the sequencer holds an instruction until ready_o, then waits for done_o
module lbc_unit (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// instruction from sequencer
	input wire logic instr_valid_i,
	input wire lbc_pkg::lbc_op_t opcode_i,
	input wire logic rung_i,
	input wire logic [lbc_pkg::LABEL_W-1:0] first_operand_i,
	input wire logic [lbc_pkg::LABEL_W-1:0] second_operand_i,
	input wire logic [lbc_pkg::PC_W-1:0] pc_i,
	input wire logic [lbc_pkg::DATA_W-1:0] dreg_rdata_i,
	// scan control
	input wire logic slim_variant_i,
	input wire logic scan_start_i,
	input wire logic err_clear_i,
	// handshake and flow result
	output logic ready_o,
	output logic done_o,
	output logic branch_o,
	output logic [lbc_pkg::PC_W-1:0] next_pc_o,
	output logic scan_end_o,
	// data register write-back
	output logic dreg_we_o,
	output logic [lbc_pkg::LABEL_W-1:0] dreg_addr_o,
	output logic [lbc_pkg::DATA_W-1:0] dreg_wdata_o,
	// status
	output logic exec_error_flag_o,
	output logic [lbc_pkg::DEPTH_W-1:0] call_depth_o
);
	lbc_pkg::lbc_state_t state;
	lbc_pkg::lbc_op_t op_q;
	logic rung_q;
	logic slim_q;
	logic [lbc_pkg::LABEL_W-1:0] opa_q;
	logic [lbc_pkg::LABEL_W-1:0] opb_q;
	logic [lbc_pkg::PC_W-1:0] pc_q;
	logic [lbc_pkg::DATA_W-1:0] data_q;
	logic [lbc_pkg::LABEL_NUM-1:0] label_known;
	logic [lbc_pkg::PC_W-1:0] stack [lbc_pkg::STACK_N];
	logic [lbc_pkg::DEPTH_W-1:0] depth;
	logic past_end;
	logic accept;
	logic exec;
	logic lbl_wr;
	logic [lbc_pkg::LABEL_W-1:0] rd_lbl;
	logic [lbc_pkg::PC_W-1:0] tgt_addr;
	logic [lbc_pkg::LABEL_W-1:0] tgt_lbl;
	logic tgt_ok;
	logic [lbc_pkg::PC_W-1:0] seq_pc;
	logic [lbc_pkg::DATA_W-1:0] dec_val;
	logic [lbc_pkg::PC_W-1:0] stack_top;
	logic next_branch;
	logic [lbc_pkg::PC_W-1:0] next_pc;
	logic next_err;
	logic next_push;
	logic next_pop;
	logic next_dwe;
	logic next_scan_end;

	assign accept = instr_valid_i && ready_o;
	assign exec = (state == lbc_pkg::st_exec);

	// markers register their own address so later branches can find them
	assign lbl_wr = accept && (opcode_i == lbc_pkg::op_label)
		&& lbc_pkg::label_ok(first_operand_i, slim_variant_i);
	assign rd_lbl = (opcode_i == lbc_pkg::op_decrement_branch_nonzero) ? second_operand_i : first_operand_i;

	lbc_label_mem u_label_mem (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(lbl_wr),
		.wr_addr_i(first_operand_i),
		.wr_data_i(pc_i),
		.rd_addr_i(rd_lbl),
		.rd_data_o(tgt_addr)
	);

	// sequencing: one instruction in flight, answer two edges after acceptance
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state <= lbc_pkg::st_idle;
			ready_o <= 1'b0;
		end else if (accept) begin
			state <= lbc_pkg::st_exec;
			ready_o <= 1'b0;
		end else begin
			state <= lbc_pkg::st_idle;
			ready_o <= 1'b1;
		end
	end

	// operand capture
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			op_q <= lbc_pkg::op_none;
			rung_q <= 1'b0;
			slim_q <= 1'b0;
			opa_q <= '0;
			opb_q <= '0;
			pc_q <= lbc_pkg::PC_RESET;
			data_q <= lbc_pkg::DATA_ZERO;
		end else if (accept) begin
			op_q <= opcode_i;
			rung_q <= rung_i;
			slim_q <= slim_variant_i;
			opa_q <= first_operand_i;
			opb_q <= second_operand_i;
			pc_q <= pc_i;
			data_q <= dreg_rdata_i;
		end
	end

	// which labels hold a valid address; a duplicate marker simply overwrites
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			label_known <= '0;
		end else if (lbl_wr) begin
			label_known[first_operand_i] <= 1'b1;
		end
	end

	assign tgt_lbl = (op_q == lbc_pkg::op_decrement_branch_nonzero) ? opb_q : opa_q;
	assign tgt_ok = lbc_pkg::label_ok(tgt_lbl, slim_q) && label_known[tgt_lbl];
	assign seq_pc = lbc_pkg::PC_W'(pc_q + lbc_pkg::PC_STEP);
	assign dec_val = lbc_pkg::DATA_W'(data_q - lbc_pkg::DEC_STEP);
	assign stack_top = stack[2'(depth - lbc_pkg::DEPTH_STEP)];

	// flow decision for the captured instruction
	always_comb begin
		next_branch = 1'b0;
		next_pc = seq_pc;
		next_err = 1'b0;
		next_push = 1'b0;
		next_pop = 1'b0;
		next_dwe = 1'b0;
		next_scan_end = 1'b0;
		case (op_q)
			lbc_pkg::op_label: begin
				next_err = !lbc_pkg::label_ok(opa_q, slim_q);
			end
			lbc_pkg::op_end: begin
				next_scan_end = 1'b1;
			end
			lbc_pkg::op_label_jump: begin
				if (rung_q && tgt_ok) begin
					next_branch = 1'b1;
					next_pc = tgt_addr;
				end else if (rung_q) begin
					next_err = 1'b1;
				end
			end
			lbc_pkg::op_label_subroutine_call: begin
				if (rung_q && (depth == lbc_pkg::STACK_DEPTH)) begin
					next_err = 1'b1;
				end else if (rung_q && tgt_ok) begin
					next_push = 1'b1;
					next_branch = 1'b1;
					next_pc = tgt_addr;
				end else if (rung_q) begin
					next_err = 1'b1;
				end
			end
			lbc_pkg::op_subroutine_return: begin
				// only legal while a call is outstanding and the end marker has been met in this scan
				if ((depth == lbc_pkg::DEPTH_EMPTY) || !past_end) begin
					next_err = 1'b1;
				end else begin
					next_pop = 1'b1;
					next_branch = 1'b1;
					next_pc = stack_top;
				end
			end
			lbc_pkg::op_decrement_branch_nonzero: begin
				if (rung_q) begin
					next_dwe = 1'b1;
					if (dec_val != lbc_pkg::DATA_ZERO) begin
						next_branch = tgt_ok;
						next_err = !tgt_ok;
						next_pc = tgt_ok ? tgt_addr : seq_pc;
					end
				end
			end
			default: begin
				next_pc = seq_pc;
			end
		endcase
	end

	// result outputs, one-cycle pulses with the address held until the next answer
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			done_o <= 1'b0;
			branch_o <= 1'b0;
			scan_end_o <= 1'b0;
			next_pc_o <= lbc_pkg::PC_RESET;
		end else begin
			done_o <= exec;
			branch_o <= exec && next_branch;
			scan_end_o <= exec && next_scan_end;
			if (exec) begin
				next_pc_o <= next_pc;
			end
		end
	end

	// data register write-back
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			dreg_we_o <= 1'b0;
			dreg_addr_o <= '0;
			dreg_wdata_o <= lbc_pkg::DATA_ZERO;
		end else begin
			dreg_we_o <= exec && next_dwe;
			if (exec && next_dwe) begin
				dreg_addr_o <= opa_q;
				dreg_wdata_o <= dec_val;
			end
		end
	end

	// return stack; a new scan discards any unreturned calls
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			depth <= lbc_pkg::DEPTH_EMPTY;
		end else if (scan_start_i) begin
			depth <= lbc_pkg::DEPTH_EMPTY;
		end else if (exec && next_push) begin
			depth <= lbc_pkg::DEPTH_W'(depth + lbc_pkg::DEPTH_STEP);
		end else if (exec && next_pop) begin
			depth <= lbc_pkg::DEPTH_W'(depth - lbc_pkg::DEPTH_STEP);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (exec && next_push) begin
			stack[depth[1:0]] <= seq_pc;
		end
	end

	assign call_depth_o = depth;

	// set once the end marker has been met in this scan
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			past_end <= 1'b0;
		end else if (exec && next_scan_end) begin
			past_end <= 1'b1;
		end else if (scan_start_i) begin
			past_end <= 1'b0;
		end
	end

	// sticky error: a new error wins over a clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			exec_error_flag_o <= 1'b0;
		end else if (exec && next_err) begin
			exec_error_flag_o <= 1'b1;
		end else if (err_clear_i) begin
			exec_error_flag_o <= 1'b0;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_taken;
		accept ##1 exec;
	endsequence

	sequence s_answer;
		done_o && ready_o;
	endsequence

	a_one_pass: assert property (s_taken |=> s_answer) else $error("answer not two edges after accept");

	a_label_range: assert property (accept && (opcode_i == lbc_pkg::op_label) && !slim_variant_i
		&& (first_operand_i > lbc_pkg::MAX_LABEL_ALL) ##1 exec |=> exec_error_flag_o)
		else $error("out-of-range label not flagged");

	a_end_stop: assert property (exec && (op_q == lbc_pkg::op_end) |=> scan_end_o && !branch_o)
		else $error("end marker did not stop scan");

	a_jump_taken: assert property (exec && (op_q == lbc_pkg::op_label_jump) && rung_q && tgt_ok
		|=> branch_o && (next_pc_o == $past(tgt_addr))) else $error("jump missed its label");

	a_jump_idle: assert property (exec && (op_q == lbc_pkg::op_label_jump) && !rung_q
		|=> done_o && !branch_o && (next_pc_o == $past(seq_pc))) else $error("jump taken with rung off");

	a_jump_no_save: assert property (exec && (op_q == lbc_pkg::op_label_jump)
		|=> $stable(depth)) else $error("jump changed return stack");

	a_call_push: assert property (exec && (op_q == lbc_pkg::op_label_subroutine_call) && rung_q
		&& tgt_ok && (depth < lbc_pkg::STACK_DEPTH) |=> branch_o
		&& (depth == lbc_pkg::DEPTH_W'($past(depth) + lbc_pkg::DEPTH_STEP)) && (stack_top == $past(seq_pc)))
		else $error("call did not save return address");

	a_call_idle: assert property (exec && (op_q == lbc_pkg::op_label_subroutine_call) && !rung_q
		|=> !branch_o && $stable(depth)) else $error("call made with rung off");

	a_return_resume: assert property (exec && (op_q == lbc_pkg::op_subroutine_return)
		&& (depth != lbc_pkg::DEPTH_EMPTY) && past_end |=> branch_o && (next_pc_o == $past(stack_top))
		&& (depth == lbc_pkg::DEPTH_W'($past(depth) - lbc_pkg::DEPTH_STEP)))
		else $error("return went to wrong address");

	a_nest_limit: assert property (exec && (op_q == lbc_pkg::op_label_subroutine_call) && rung_q
		&& (depth == lbc_pkg::STACK_DEPTH) |=> exec_error_flag_o && !branch_o && (depth == lbc_pkg::STACK_DEPTH))
		else $error("fifth call not refused");

	a_bad_return: assert property (exec && (op_q == lbc_pkg::op_subroutine_return)
		&& ((depth == lbc_pkg::DEPTH_EMPTY) || !past_end) |=> exec_error_flag_o && !branch_o)
		else $error("stray return not flagged");

	a_loop_write: assert property (exec && (op_q == lbc_pkg::op_decrement_branch_nonzero) && rung_q
		|=> dreg_we_o && (dreg_wdata_o == lbc_pkg::DATA_W'($past(data_q) - lbc_pkg::DEC_STEP))
		&& (dreg_addr_o == $past(opa_q))) else $error("loop decrement wrong");

	a_loop_branch: assert property (exec && (op_q == lbc_pkg::op_decrement_branch_nonzero) && rung_q
		&& tgt_ok |=> (branch_o == ($past(dec_val) != lbc_pkg::DATA_ZERO)))
		else $error("loop branch decision wrong");

	a_loop_idle: assert property (exec && (op_q == lbc_pkg::op_decrement_branch_nonzero) && !rung_q
		|=> !dreg_we_o && !branch_o) else $error("loop acted with rung off");
endmodule

/* lbc_pkg.sv */
// constants, opcode encoding and shared helpers for the ladder branch/call unit
// assumes a sequencer that presents one decoded instruction at a time on ref_clk_i
//
// How it works
// - label markers accept 0..127 on all-in-one, 0..255 on slim; mark targets.
// - end marker stops sequential scan; code after it runs only by branch.
// - jump with rung true loads target address of label named by first operand.
// - jump with rung false continues with next sequential instruction.
// - taken jump saves no return address and never returns by itself.
// - call with rung true saves next address and branches to first-operand label.
// - call with rung false makes no call and continues sequentially.
// - return resumes at the instruction after the most recent call.
// - calls nest four deep; a fifth level raises the execution error flag.
// - return outside the end of a labelled subroutine raises the error flag.
// - loop with rung true decrements first-operand data register by one, writes back.
// - nonzero result branches to second-operand label; zero falls through.
package lbc_pkg;
	localparam int PC_W = 16;
	localparam int DATA_W = 16;
	localparam int LABEL_W = 8;
	localparam int LABEL_NUM = 256;
	localparam int DEPTH_W = 3;
	localparam int STACK_N = 4;
	localparam logic [DEPTH_W-1:0] STACK_DEPTH = 3'h4;
	localparam logic [DEPTH_W-1:0] DEPTH_STEP = 3'h1;
	localparam logic [DEPTH_W-1:0] DEPTH_EMPTY = 3'h0;
	localparam logic [LABEL_W-1:0] MAX_LABEL_ALL = 8'h7f;
	localparam logic [LABEL_W-1:0] MAX_LABEL_SLIM = 8'hff;
	localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] DEC_STEP = 16'h0001;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		op_none = 3'h0,
		op_label = 3'h1,
		op_end = 3'h2,
		op_label_jump = 3'h3,
		op_label_subroutine_call = 3'h4,
		op_subroutine_return = 3'h5,
		op_decrement_branch_nonzero = 3'h6
	} lbc_op_t;

	typedef enum logic {
		st_idle,
		st_exec
	} lbc_state_t;

	// label number legal for the selected controller variant
	function automatic logic label_ok(input logic [LABEL_W-1:0] lbl, input logic slim);
		label_ok = slim ? (lbl <= MAX_LABEL_SLIM) : (lbl <= MAX_LABEL_ALL);
	endfunction
endpackage

/* lbc_label_mem.sv */
// label target table: one program address per label number
// assumes writer and reader share ref_clk_i; read data is registered
module lbc_label_mem (
	// clock
	input wire logic ref_clk_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [lbc_pkg::LABEL_W-1:0] wr_addr_i,
	input wire logic [lbc_pkg::PC_W-1:0] wr_data_i,
	// read port
	input wire logic [lbc_pkg::LABEL_W-1:0] rd_addr_i,
	output logic [lbc_pkg::PC_W-1:0] rd_data_o
);
	logic [lbc_pkg::PC_W-1:0] mem [lbc_pkg::LABEL_NUM];

	// no reset: validity is tracked beside the table by the owner
	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// read-during-write returns the old word
	always_ff @(posedge ref_clk_i) begin
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

/* lbc_dreg_model.sv */
// data register file seen by the flow unit from the sequencer side
// assumes write-back pulses come on ref_clk_i; reads are combinational
module lbc_dreg_model (
	// clock
	input wire logic ref_clk_i,
	// read port
	input wire logic [lbc_pkg::LABEL_W-1:0] rd_addr_i,
	output logic [lbc_pkg::DATA_W-1:0] rd_data_o,
	// write-back port
	input wire logic we_i,
	input wire logic [lbc_pkg::LABEL_W-1:0] wr_addr_i,
	input wire logic [lbc_pkg::DATA_W-1:0] wr_data_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [lbc_pkg::DATA_W-1:0] regs [256];
	// register n starts at n, so small loop counts are at hand
	initial for (int i = 0; i < 256; i++) regs[i] = 16'(i);
	assign rd_data_o = regs[rd_addr_i];
	always @(posedge ref_clk_i) if (we_i) regs[wr_addr_i] <= wr_data_i;
endmodule

/* tb_ladder_branch_call_unit.sv */
// self-checking bench for lbc_unit with a reference model of program flow
// assumes lbc_pkg and lbc_dreg_model are compiled first
module tb_ladder_branch_call_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0, srst_i = 1'b1, instr_valid_i = 1'b0, rung_i = 1'b0;
	logic slim_variant_i = 1'b0, scan_start_i = 1'b0, err_clear_i = 1'b0;
	lbc_pkg::lbc_op_t opcode_i = lbc_pkg::op_none;
	logic [7:0] first_operand_i = 8'h00, second_operand_i = 8'h00, dreg_addr_o;
	logic [15:0] pc_i = 16'h0000, dreg_rdata_i, next_pc_o, dreg_wdata_o;
	logic ready_o, done_o, branch_o, scan_end_o, dreg_we_o, exec_error_flag_o;
	logic [2:0] call_depth_o;
	int err_total = 0, checks_done = 0, seed = 32'he147;
	logic [46:0] expq [$];
	logic [15:0] lbl [logic [7:0]];
	logic [15:0] stk [$];
	logic end_seen = 1'b0, eflag = 1'b0;
	logic [7:0] picks [3] = '{8'h05, 8'h7f, 8'h09};

	always #2.5 ref_clk_i = ~ref_clk_i;

	lbc_unit dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i), .opcode_i(opcode_i),
		.rung_i(rung_i), .first_operand_i(first_operand_i), .second_operand_i(second_operand_i), .pc_i(pc_i),
		.dreg_rdata_i(dreg_rdata_i), .slim_variant_i(slim_variant_i), .scan_start_i(scan_start_i),
		.err_clear_i(err_clear_i), .ready_o(ready_o), .done_o(done_o), .branch_o(branch_o),
		.next_pc_o(next_pc_o), .scan_end_o(scan_end_o), .dreg_we_o(dreg_we_o), .dreg_addr_o(dreg_addr_o),
		.dreg_wdata_o(dreg_wdata_o), .exec_error_flag_o(exec_error_flag_o), .call_depth_o(call_depth_o));

	lbc_dreg_model regs (.ref_clk_i(ref_clk_i), .rd_addr_i(first_operand_i), .rd_data_o(dreg_rdata_i),
		.we_i(dreg_we_o), .wr_addr_i(dreg_addr_o), .wr_data_i(dreg_wdata_o));

	task automatic report_and_stop();
		if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(string name, logic [46:0] e, logic [46:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", name, e, g);
		end
	endtask

	function automatic logic okk(logic [7:0] l);
		return lbl.exists(l) && (slim_variant_i || l <= 8'h7f);
	endfunction

	// hold the offer until an edge sees ready_o, then note the expected answer
	task automatic issue(lbc_pkg::lbc_op_t op, logic r, logic [7:0] f, logic [7:0] s, logic [15:0] pc);
		logic br, se, er, we;
		logic [15:0] np, wd, rd;
		int n;
		br = 1'b0;
		se = 1'b0;
		er = 1'b0;
		we = 1'b0;
		wd = 16'h0000;
		np = pc + 16'h0001;
		n = 0;
		@(posedge ref_clk_i);
		instr_valid_i <= 1'b1;
		opcode_i <= op;
		rung_i <= r;
		first_operand_i <= f;
		second_operand_i <= s;
		pc_i <= pc;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (ready_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			report_and_stop();
		end
		rd = dreg_rdata_i;
		instr_valid_i <= 1'b0;
		case (op)
			lbc_pkg::op_label: if (slim_variant_i || f <= 8'h7f) lbl[f] = pc; else er = 1'b1;
			lbc_pkg::op_end: begin
				se = 1'b1;
				end_seen = 1'b1;
			end
			lbc_pkg::op_label_jump: if (r) if (okk(f)) {br, np} = {1'b1, lbl[f]}; else er = 1'b1;
			lbc_pkg::op_label_subroutine_call: if (r) begin
				if (stk.size() < 4 && okk(f)) begin
					stk.push_back(pc + 16'h0001);
					{br, np} = {1'b1, lbl[f]};
				end else er = 1'b1;
			end
			lbc_pkg::op_subroutine_return: if (stk.size() > 0 && end_seen) {br, np} = {1'b1, stk.pop_back()};
				else er = 1'b1;
			lbc_pkg::op_decrement_branch_nonzero: if (r) begin
				we = 1'b1;
				wd = rd - 16'h0001;
				if (wd != 16'h0000) if (okk(s)) {br, np} = {1'b1, lbl[s]}; else er = 1'b1;
			end
			default: ;
		endcase
		eflag = eflag | er;
		expq.push_back({br, np, se, eflag, we, we ? f : 8'h00, wd, 3'(stk.size())});
	endtask

	// pulse scan start and error clear, and pick the controller variant
	task automatic ctl(logic sc, logic ec, logic sl);
		@(posedge ref_clk_i);
		scan_start_i <= sc;
		err_clear_i <= ec;
		slim_variant_i <= sl;
		@(posedge ref_clk_i);
		scan_start_i <= 1'b0;
		err_clear_i <= 1'b0;
		if (sc) stk.delete();
		if (sc) end_seen = 1'b0;
		if (ec) eflag = 1'b0;
	endtask

	always @(posedge ref_clk_i) if (done_o === 1'b1) begin
		if (expq.size() == 0) chk("unexpected done", 47'h0, 47'h1);
		else chk("result", expq.pop_front(), {branch_o, next_pc_o, scan_end_o, exec_error_flag_o, dreg_we_o,
			dreg_we_o ? dreg_addr_o : 8'h00, dreg_we_o ? dreg_wdata_o : 16'h0000, call_depth_o});
	end

	initial begin
		repeat (8) @(posedge ref_clk_i);
		chk("reset ready", 47'h0, {46'h0, ready_o});
		srst_i <= 1'b0;
		issue(lbc_pkg::op_label, 1'b0, 8'h05, 8'h00, 16'h0100);
		issue(lbc_pkg::op_label, 1'b0, 8'h7f, 8'h00, 16'h0200);
		issue(lbc_pkg::op_label, 1'b0, 8'h80, 8'h00, 16'h0280);
		ctl(1'b0, 1'b1, 1'b1);
		issue(lbc_pkg::op_label, 1'b0, 8'hc8, 8'h00, 16'h0300);
		issue(lbc_pkg::op_label_jump, 1'b0, 8'h05, 8'h00, 16'h0010);
		issue(lbc_pkg::op_label_jump, 1'b1, 8'hc8, 8'h00, 16'h0011);
		issue(lbc_pkg::op_label_jump, 1'b1, 8'h09, 8'h00, 16'h0012);
		ctl(1'b0, 1'b1, 1'b0);
		issue(lbc_pkg::op_label_jump, 1'b1, 8'hc8, 8'h00, 16'h0013);
		issue(lbc_pkg::op_subroutine_return, 1'b1, 8'h00, 8'h00, 16'h0014);
		issue(lbc_pkg::op_end, 1'b1, 8'h00, 8'h00, 16'h0015);
		issue(lbc_pkg::op_subroutine_return, 1'b1, 8'h00, 8'h00, 16'h0016);
		ctl(1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) issue(lbc_pkg::op_label_subroutine_call, 1'b1, 8'h7f, 8'h00, 16'h0020 + 16'(i));
		issue(lbc_pkg::op_label_subroutine_call, 1'b0, 8'h05, 8'h00, 16'h0030);
		issue(lbc_pkg::op_label_jump, 1'b1, 8'h05, 8'h00, 16'h0031);
		issue(lbc_pkg::op_label_subroutine_call, 1'b1, 8'h05, 8'h00, 16'h0032);
		for (int i = 0; i < 5; i++) issue(lbc_pkg::op_subroutine_return, 1'b1, 8'h00, 8'h00, 16'h0040);
		ctl(1'b1, 1'b1, 1'b0);
		issue(lbc_pkg::op_label_subroutine_call, 1'b1, 8'h05, 8'h00, 16'h0050);
		issue(lbc_pkg::op_subroutine_return, 1'b1, 8'h00, 8'h00, 16'h0051);
		issue(lbc_pkg::op_decrement_branch_nonzero, 1'b0, 8'h03, 8'h05, 16'h0060);
		for (int i = 0; i < 4; i++) begin
			ctl(1'b0, 1'b0, 1'b0);
			issue(lbc_pkg::op_decrement_branch_nonzero, 1'b1, (i < 3) ? 8'h03 : 8'h00, 8'h05, 16'h0061);
		end
		ctl(1'b0, 1'b1, 1'b0);
		issue(lbc_pkg::op_decrement_branch_nonzero, 1'b1, 8'h04, 8'h09, 16'h0062);
		ctl(1'b0, 1'b1, 1'b0);
		// random rung and pc stress the jump decode
		repeat (16) issue(lbc_pkg::op_label_jump, 1'($random(seed)), picks[$unsigned($random(seed)) % 3], 8'h00,
			16'($random(seed)));
		repeat (4) @(posedge ref_clk_i);
		chk("pending answers", 47'h0, 47'(expq.size()));
		report_and_stop();
	end
endmodule
